// File: core/hbmw_pkg.sv
/*
  Package of the host bridge window block: configuration offsets, field
  positions, reset values, the capability block layout and carrier structs.
  Assumes 32-bit dword-addressed configuration cycles and 32-bit memory addresses.
*/
package hbmw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration offsets (byte addresses, dword aligned)
  localparam logic [7:0] CFG_CAP_PTR_OFFSET = 8'h34;
  localparam logic [7:0] CFG_EGRESS_WIN_OFFSET = 8'h40;
  localparam logic [7:0] CFG_HUB_WIN_OFFSET = 8'h44;
  localparam logic [7:0] CFG_CAP_BLOCK_OFFSET = 8'he0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and constant values
  localparam logic [7:0] CAP_PTR_VALUE = CFG_CAP_BLOCK_OFFSET;
  localparam logic [19:0] EGRESS_BASE_RESET = 20'h00000;
  localparam logic [17:0] HUB_BASE_RESET = 18'h00000;
  localparam logic ENABLE_RESET = 1'h0;

  // Capability block header: product-specific id, end of chain, arbitrary payload
  localparam logic [7:0] CAP_ID_VENDOR_SPECIFIC = 8'h09;
  localparam logic [7:0] CAP_NEXT_END = 8'h00;
  localparam logic [7:0] CAP_BLOCK_LENGTH = 8'h0c;
  localparam logic [7:0] CAP_BLOCK_VERSION = 8'h01;
  localparam int CAP_BLOCK_WORDS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int EGRESS_BASE_LSB = 12;
  localparam int HUB_BASE_LSB = 14;
  localparam int ENABLE_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] offset;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } hbmw_cfg_req_type;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } hbmw_mem_req_type;

  typedef struct packed {
    logic egress_claim;
    logic hub_claim;
    logic [11:0] egress_offset;
    logic [13:0] hub_offset;
  } hbmw_claim_type;

endpackage : hbmw_pkg

// File: core/hbmw_cap_rom.sv
/*
  Small read-only store of the first capability block, dword indexed.
  Assumes reads are synchronous; data appear one cycle after the index.
*/
`timescale 1ns/1ps
module hbmw_cap_rom (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] word_index,
  output logic [31:0] read_data
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] hbmw_cap_word(input logic [1:0] idx);
    case (idx)
      2'h0: hbmw_cap_word = {hbmw_pkg::CAP_BLOCK_VERSION, hbmw_pkg::CAP_BLOCK_LENGTH,
                             hbmw_pkg::CAP_NEXT_END, hbmw_pkg::CAP_ID_VENDOR_SPECIFIC};
      default: hbmw_cap_word = 32'h00000000;
    endcase
  endfunction : hbmw_cap_word

  // Registered output adds a cycle; capability reads answer one cycle after register file reads
  always_ff @(posedge core_clk) begin
    if (reset) begin
      read_data <= 32'h00000000;
    end else begin
      read_data <= hbmw_cap_word(word_index);
    end
  end

endmodule : hbmw_cap_rom

// File: core/hbmw_bridge_windows.sv
/*
  Configuration registers of bridge function 0: capability pointer, first
  capability block, and two memory windows with claim decode.
  Assumes one clock; configuration and memory requests come from logic on core_clk.
  Assumes software keeps the windows apart; on overlap the egress window claims.
  A read taken while a capability read is pending is dropped.
*/
`timescale 1ns/1ps
// Overview of operation
// - Capability pointer at 34h is read-only and returns E0h.
// - Block at E0h is the product-specific capability, first in the chain.
// - Egress window register at 40h: writable base bits 31:12, reset zero.
// - Egress window is a naturally aligned 4 KB block in 4 GB space.
// - Egress enable clear: no memory access claimed for that window.
// - Egress enable set: claim accesses inside window, decode to egress registers.
// - Egress window disabled after reset; software writes 1 to enable.
// - Egress window must not alias onto ordinary memory decoded elsewhere.
// - Hub window register at 44h: writable base bits 31:14, reset zero.
// - Hub window is a naturally aligned 16 KB block in 4 GB space.
// - Hub enable clear: no memory access claimed for that window.
// - Hub enable set: claim accesses inside window unless egress claims them, decode to hub registers.
// - Hub window disabled after reset; software writes 1 to enable.
// - Hub window must not alias onto ordinary memory decoded elsewhere.
module hbmw_bridge_windows (
  input wire logic core_clk,
  input wire logic reset,
  input wire hbmw_pkg::hbmw_cfg_req_type cfg_req,
  output logic cfg_rd_valid,
  output logic [31:0] cfg_rd_data,
  input wire hbmw_pkg::hbmw_mem_req_type mem_req,
  output hbmw_pkg::hbmw_claim_type mem_claim,
  output logic mem_claim_valid
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    HBMW_RD_IDLE = 2'b01,
    HBMW_RD_CAP = 2'b10
  } hbmw_rd_state_type;

  // Register select
  typedef enum logic [3:0] {
    HBMW_SEL_NONE = 4'b0001,
    HBMW_SEL_CAP_PTR = 4'b0010,
    HBMW_SEL_EGRESS = 4'b0100,
    HBMW_SEL_HUB = 4'b1000
  } hbmw_sel_type;

  // Window size masks
  localparam logic [31:0] EGRESS_SIZE_MASK = ~(32'hffffffff << hbmw_pkg::EGRESS_BASE_LSB);
  localparam logic [31:0] HUB_SIZE_MASK = ~(32'hffffffff << hbmw_pkg::HUB_BASE_LSB);

  typedef struct packed {
    logic [19:0] egress_base;
    logic egress_enable;
    logic [17:0] hub_base;
    logic hub_enable;
    hbmw_rd_state_type rd_state;
    logic rd_valid;
    logic [31:0] rd_data;
    hbmw_pkg::hbmw_claim_type claim;
    logic claim_valid;
  } hbmw_state_type;

  hbmw_state_type state_reg;
  hbmw_state_type state_next;
  logic [31:0] cap_word;
  logic [1:0] cap_index;
  hbmw_sel_type cfg_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-enable merge; disabled bytes keep their old value
  function automatic logic [31:0] hbmw_merge(input logic [31:0] old_value,
                                             input logic [31:0] new_value,
                                             input logic [3:0] be);
    logic [31:0] merged;
    merged = old_value;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merged[8*i +: 8] = new_value[8*i +: 8];
      end
    end
    hbmw_merge = merged;
  endfunction : hbmw_merge

  // Capability block spans four dwords from the pointed-to offset
  function automatic logic hbmw_in_cap_block(input logic [7:0] offset);
    hbmw_in_cap_block = (offset >= hbmw_pkg::CFG_CAP_BLOCK_OFFSET) &&
                        (offset < hbmw_pkg::CFG_CAP_BLOCK_OFFSET + 8'(4 * hbmw_pkg::CAP_BLOCK_WORDS));
  endfunction : hbmw_in_cap_block

  // One decode serves both the write and the read path
  function automatic hbmw_sel_type hbmw_decode(input logic [7:0] offset);
    case (offset)
      hbmw_pkg::CFG_CAP_PTR_OFFSET: hbmw_decode = HBMW_SEL_CAP_PTR;
      hbmw_pkg::CFG_EGRESS_WIN_OFFSET: hbmw_decode = HBMW_SEL_EGRESS;
      hbmw_pkg::CFG_HUB_WIN_OFFSET: hbmw_decode = HBMW_SEL_HUB;
      default: hbmw_decode = HBMW_SEL_NONE;
    endcase
  endfunction : hbmw_decode

  // Natural alignment: bits inside the window size never take part in the match
  function automatic logic hbmw_window_hit(input logic [31:0] addr,
                                           input logic [31:0] window_word,
                                           input logic [31:0] size_mask);
    hbmw_window_hit = ((addr & ~size_mask) == (window_word & ~size_mask));
  endfunction : hbmw_window_hit

  ////////////////////////////////////////////////////////////////////////////
  // Capability block store
  // Dword index inside the block; every offset reaches the store, only block reads use its word
  assign cap_index = 2'((cfg_req.offset - hbmw_pkg::CFG_CAP_BLOCK_OFFSET) >> 2);
  assign cfg_sel = hbmw_decode(cfg_req.offset);

  hbmw_cap_rom cap_rom (
    .core_clk(core_clk),
    .reset(reset),
    .word_index(cap_index),
    .read_data(cap_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [31:0] egress_word;
    logic [31:0] hub_word;
    logic [31:0] merged;
    logic egress_hit;
    logic hub_hit;
    egress_word = {state_reg.egress_base, 11'h0, state_reg.egress_enable};
    hub_word = {state_reg.hub_base, 13'h0, state_reg.hub_enable};
    merged = 32'h00000000;
    egress_hit = 1'b0;
    hub_hit = 1'b0;
    state_next = state_reg;
    state_next.rd_valid = 1'b0;
    state_next.rd_state = HBMW_RD_IDLE;

    // Configuration writes; reserved bits simply drop
    if (cfg_req.wr) begin
      case (cfg_sel)
        HBMW_SEL_EGRESS: begin
          merged = hbmw_merge(egress_word, cfg_req.wdata, cfg_req.byte_en);
          state_next.egress_base = merged[31:hbmw_pkg::EGRESS_BASE_LSB];
          state_next.egress_enable = merged[hbmw_pkg::ENABLE_BIT];
        end
        HBMW_SEL_HUB: begin
          merged = hbmw_merge(hub_word, cfg_req.wdata, cfg_req.byte_en);
          state_next.hub_base = merged[31:hbmw_pkg::HUB_BASE_LSB];
          state_next.hub_enable = merged[hbmw_pkg::ENABLE_BIT];
        end
        default: begin
          // Pointer, capability block and unmapped offsets ignore writes
        end
      endcase
    end

    // Configuration reads answer one cycle later; capability words wait for the store
    // No second read is taken while one is pending, so the store needs no queue
    case (state_reg.rd_state)
      HBMW_RD_CAP: begin
        state_next.rd_valid = 1'b1;
        state_next.rd_data = cap_word;
      end
      default: begin
        if (cfg_req.rd) begin
          if (hbmw_in_cap_block(cfg_req.offset)) begin
            state_next.rd_state = HBMW_RD_CAP;
          end else begin
            state_next.rd_valid = 1'b1;
            case (cfg_sel)
              HBMW_SEL_CAP_PTR: state_next.rd_data = {24'h000000, hbmw_pkg::CAP_PTR_VALUE};
              HBMW_SEL_EGRESS: state_next.rd_data = egress_word;
              HBMW_SEL_HUB: state_next.rd_data = hub_word;
              default: state_next.rd_data = 32'h00000000;
            endcase
          end
        end
      end
    endcase

    // Memory claim decode
    egress_hit = hbmw_window_hit(mem_req.addr, egress_word, EGRESS_SIZE_MASK);
    hub_hit = hbmw_window_hit(mem_req.addr, hub_word, HUB_SIZE_MASK);
    state_next.claim_valid = mem_req.valid;
    state_next.claim.egress_claim = mem_req.valid && state_reg.egress_enable && egress_hit;
    state_next.claim.hub_claim = mem_req.valid && state_reg.hub_enable && hub_hit;
    // Overlapping windows are a software error; egress wins so one target claims
    if (state_next.claim.egress_claim) begin
      state_next.claim.hub_claim = 1'b0;
    end
    state_next.claim.egress_offset = mem_req.addr[11:0];
    state_next.claim.hub_offset = mem_req.addr[13:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      // Every field reset explicitly; nothing survives from before reset
      state_reg <= '0;
      state_reg.rd_valid <= 1'b0;
      state_reg.rd_data <= 32'h00000000;
      state_reg.claim <= '0;
      state_reg.claim_valid <= 1'b0;
      state_reg.egress_base <= hbmw_pkg::EGRESS_BASE_RESET;
      state_reg.egress_enable <= hbmw_pkg::ENABLE_RESET;
      state_reg.hub_base <= hbmw_pkg::HUB_BASE_RESET;
      state_reg.hub_enable <= hbmw_pkg::ENABLE_RESET;
      state_reg.rd_state <= HBMW_RD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state register
  assign cfg_rd_valid = state_reg.rd_valid;
  assign cfg_rd_data = state_reg.rd_data;
  assign mem_claim = state_reg.claim;
  assign mem_claim_valid = state_reg.claim_valid;

endmodule : hbmw_bridge_windows

// File: tb/hbmw_sva.sv
/* Port checker of the window block.
   Bound to hbmw_bridge_windows; sees its ports only. */
`timescale 1ns/1ps
module hbmw_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire hbmw_pkg::hbmw_cfg_req_type cfg_req,
  input wire logic cfg_rd_valid,
  input wire logic [31:0] cfg_rd_data,
  input wire hbmw_pkg::hbmw_mem_req_type mem_req,
  input wire hbmw_pkg::hbmw_claim_type mem_claim,
  input wire logic mem_claim_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Window words as software wrote them, byte enables applied
  logic [31:0] eg_win_reg;
  logic [31:0] hub_win_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      eg_win_reg <= 32'h00000000;
      hub_win_reg <= 32'h00000000;
    end else if (cfg_req.wr) begin
      for (int i = 0; i < 4; i++) begin
        if (cfg_req.byte_en[i] && cfg_req.offset == 8'h40) eg_win_reg[8*i +: 8] <= cfg_req.wdata[8*i +: 8];
        if (cfg_req.byte_en[i] && cfg_req.offset == 8'h44) hub_win_reg[8*i +: 8] <= cfg_req.wdata[8*i +: 8];
      end
    end
  end
  AST_EG_OFF: assert property (!eg_win_reg[0] |=> !mem_claim.egress_claim) else $error("egress claim disabled");
  AST_HUB_OFF: assert property (!hub_win_reg[0] |=> !mem_claim.hub_claim) else $error("hub claim disabled");
  AST_EG_HIT: assert property (mem_req.valid && eg_win_reg[0] && mem_req.addr[31:12] == eg_win_reg[31:12]
    |=> mem_claim.egress_claim) else $error("egress access not claimed");
  AST_HUB_HIT: assert property (mem_req.valid && hub_win_reg[0] && mem_req.addr[31:14] == hub_win_reg[31:14]
    && !(eg_win_reg[0] && mem_req.addr[31:12] == eg_win_reg[31:12]) |=> mem_claim.hub_claim)
    else $error("hub access not claimed");
  AST_CAP_PTR: assert property (cfg_req.rd && cfg_req.offset == 8'h34
    |=> cfg_rd_valid && cfg_rd_data == 32'h000000e0) else $error("pointer read wrong");
  AST_CAP_BLOCK: assert property (cfg_req.rd && cfg_req.offset == 8'he0
    |-> ##2 cfg_rd_valid && cfg_rd_data[7:0] == 8'h09) else $error("capability id wrong");
  AST_EG_RSV: assert property (cfg_req.rd && cfg_req.offset == 8'h40
    |=> cfg_rd_valid && cfg_rd_data[11:1] == 11'h000) else $error("egress reserved bits set");
  AST_HUB_RSV: assert property (cfg_req.rd && cfg_req.offset == 8'h44
    |=> cfg_rd_valid && cfg_rd_data[13:1] == 13'h0000) else $error("hub reserved bits set");
  AST_CLAIM_PIPE: assert property (mem_req.valid |=> mem_claim_valid) else $error("access not answered");
  AST_NO_STRAY: assert property (!mem_claim_valid
    |-> !mem_claim.egress_claim && !mem_claim.hub_claim) else $error("claim without access");
  AST_NO_ALIAS: assert property (!(mem_claim.egress_claim && mem_claim.hub_claim)) else $error("double claim");
  AST_OFFSETS: assert property (mem_req.valid |=> mem_claim.egress_offset == $past(mem_req.addr[11:0])
    && mem_claim.hub_offset == $past(mem_req.addr[13:0])) else $error("claim offset wrong");
endmodule : hbmw_sva
////////////////////////////////////////////////////////////
bind hbmw_bridge_windows hbmw_sva hbmw_sva_i (.core_clk(core_clk), .reset(reset), .cfg_req(cfg_req),
  .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data), .mem_req(mem_req), .mem_claim(mem_claim),
  .mem_claim_valid(mem_claim_valid));

// File: tb/hbmw_host_model.sv
/* Host side: issues config and memory requests.
   Assumes tasks start just after a rising edge. */
`timescale 1ns/1ps
module hbmw_host_model (
  input wire logic core_clk,
  output hbmw_pkg::hbmw_cfg_req_type cfg_req,
  output hbmw_pkg::hbmw_mem_req_type mem_req
);
  initial begin
    cfg_req = '0;
    mem_req = '0;
  end
  ////////////////////////////////////////////////////////////
  // Idle cycle after each request keeps capability read spacing
  task automatic cfg(input logic wr, input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
    cfg_req = {~wr, wr, off, be, d};
    @(posedge core_clk);
    #1;
    cfg_req = {2'b00, ~off, ~be, ~d}; // Released bus flips, never stale
    @(posedge core_clk);
    #1;
  endtask : cfg
  task automatic mem(input logic v, input logic [31:0] a);
    mem_req = {v, v ? a : ~mem_req.addr};
    @(posedge core_clk);
    #1;
  endtask : mem
endmodule : hbmw_host_model

// File: tb/test_host_bridge_mmio_window_bars.sv
/* Self-checking bench of the window block.
   Assumes the host model drives all requests. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; $display("mismatch %s %h %h", n, e, s); end end
module test_host_bridge_mmio_window_bars;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  hbmw_pkg::hbmw_cfg_req_type cfg_req;
  hbmw_pkg::hbmw_mem_req_type mem_req;
  hbmw_pkg::hbmw_claim_type mem_claim, ec;
  logic cfg_rd_valid, mem_claim_valid;
  logic [31:0] cfg_rd_data, er, a;
  logic [31:0] rd_q[$];
  hbmw_pkg::hbmw_claim_type cl_q[$];
  int errors = 0;
  int compares = 0;
  int seed = 32;
  always #20 core_clk = ~core_clk;
  hbmw_host_model hbmw_host_model_i (.core_clk(core_clk), .cfg_req(cfg_req), .mem_req(mem_req));
  hbmw_bridge_windows hbmw_bridge_windows_i (.core_clk(core_clk), .reset(reset), .cfg_req(cfg_req),
    .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data), .mem_req(mem_req), .mem_claim(mem_claim),
    .mem_claim_valid(mem_claim_valid));
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic drain();
    for (int k = 0; k < 20 && rd_q.size() + cl_q.size() > 0; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (rd_q.size() + cl_q.size() > 0) errors++;
  endtask : drain
  task automatic rd(input logic [7:0] off, input logic [31:0] e);
    rd_q.push_back(e);
    hbmw_host_model_i.cfg(1'b0, off, 4'h0, 32'h0);
  endtask : rd
  task automatic acc(input logic [31:0] ad, input logic eg, input logic hub);
    cl_q.push_back({eg, hub, ad[11:0], ad[13:0]});
    hbmw_host_model_i.mem(1'b1, ad);
  endtask : acc
  always @(negedge core_clk) begin
    if (cfg_rd_valid === 1'b1) begin
      er = rd_q.size() > 0 ? rd_q.pop_front() : 32'hx;
      `CHK("read", er, cfg_rd_data)
    end
    if (mem_claim_valid === 1'b1) begin
      ec = cl_q.size() > 0 ? cl_q.pop_front() : 'x;
      `CHK("claim", ec, mem_claim)
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    reset = 1'b0;
    @(posedge core_clk);
    #1;
    rd(8'h34, 32'h000000e0);
    hbmw_host_model_i.cfg(1'b1, 8'h34, 4'hf, 32'h0);
    rd(8'h34, 32'h000000e0);
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h0);
    rd(8'h3c, 32'h0);
    rd(8'he0, 32'h010c0009);
    acc(32'h00000010, 1'b0, 1'b0);
    hbmw_host_model_i.mem(1'b0, 32'h0);
    hbmw_host_model_i.cfg(1'b1, 8'h40, 4'hf, 32'hffffffff);
    hbmw_host_model_i.cfg(1'b1, 8'h44, 4'hc, 32'habcdfffe);
    hbmw_host_model_i.cfg(1'b1, 8'h44, 4'h1, 32'h000000ff);
    rd(8'h40, 32'hfffff001);
    rd(8'h44, 32'habcd0001);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 12; i++) begin
        a = $random(seed);
        if (i % 3 == 0) a[31:12] = 20'hfffff;
        if (i % 3 == 1) a[31:14] = 18'h2af34;
        acc(a, p == 0 && a[31:12] == 20'hfffff, a[31:14] == 18'h2af34);
      end
      hbmw_host_model_i.mem(1'b0, 32'h0);
      hbmw_host_model_i.cfg(1'b1, 8'h40, 4'h1, 32'h0);
    end
    hbmw_host_model_i.cfg(1'b1, 8'h40, 4'hf, 32'habcd1001);
    rd(8'h40, 32'habcd1001);
    acc(32'habcd1010, 1'b1, 1'b0);
    acc(32'habcd2020, 1'b0, 1'b1);
    hbmw_host_model_i.mem(1'b0, 32'h0);
    drain();
    if (rd_q.size() + cl_q.size() == 0) begin
      reset = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      reset = 1'b0;
      @(posedge core_clk);
      #1;
      rd(8'h40, 32'h0);
      rd(8'h44, 32'h0);
      acc(32'habcd1010, 1'b0, 1'b0);
      hbmw_host_model_i.mem(1'b0, 32'h0);
      drain();
    end
    print_verdict();
  end
endmodule : test_host_bridge_mmio_window_bars
